// [fsric_consts.svh]
`ifndef FSRIC_CONSTS_SVH
`define FSRIC_CONSTS_SVH
// Register byte offsets
`define FSRIC_OFF_CFG     8'h00
`define FSRIC_OFF_ERRCFG  8'h04
`define FSRIC_OFF_STAT    8'h08
`define FSRIC_OFF_ERRSTAT 8'h0c
`define FSRIC_OFF_SEC     8'h10
`define FSRIC_OFF_PPROT   8'h14
`define FSRIC_OFF_DPROT   8'h18
`define FSRIC_OFF_OPT     8'h1c
`define FSRIC_OFF_IDX     8'h20
`define FSRIC_OFF_HI      8'h24
`define FSRIC_OFF_LO      8'h28
`define FSRIC_OFF_BLKCFG  8'h2c
// Field positions
`define FSRIC_BIT_CMD_COMPLETE_IRQ_EN    7
`define FSRIC_BIT_CMD_COMPLETE_FLAG    7
`define FSRIC_BIT_DFD     1
`define FSRIC_BIT_SFD     0
// Configuration field and encodings
`define FSRIC_CFG_BASE    23'h7fff00
`define FSRIC_SEC_UNSEC   2'b10
`define FSRIC_KEY_EN      2'b10
`define FSRIC_KEY_ZERO    16'h0000
`define FSRIC_KEY_ONES    16'hffff
// Fallback values: everything protected, secured, backdoor disabled
`define FSRIC_PPROT_DEF   8'h00
`define FSRIC_DPROT_DEF   8'h00
`define FSRIC_OPT_DEF     8'hff
`define FSRIC_SEC_DEF     8'hff
// Reset sequence steps and the last command object index
`define FSRIC_STEP_HOLD   3'h4
`define FSRIC_STEP_LAST   3'h6
`define FSRIC_CCOB_LAST   3'h5
`define FSRIC_STEP_PROT   3'h5
// Byte offsets of the protection word and the option and security word
`define FSRIC_CFG_PROTW   23'h00000c
`define FSRIC_CFG_OPTW    23'h00000e
`endif

// [fsric_pkg.sv]
`default_nettype none
package fsric_pkg;
  typedef enum logic [4:0] {
    S_HOLD  = 5'h01,
    S_LOAD  = 5'h02,
    S_IDLE  = 5'h04,
    S_BDKEY = 5'h08,
    S_ENG   = 5'h10
  } fsric_state_t;

  typedef struct packed {
    fsric_state_t      state;
    logic [2:0]        step;
    logic              seqErr;
    logic              cmd_complete_flag;
    logic              cmd_complete_irq_en;
    logic              double_fault_irq_en;
    logic              single_fault_irq_en;
    logic              double_fault_flag;
    logic              single_fault_flag;
    logic [1:0]        verify_error_status;
    logic [7:0]        sec;
    logic [7:0]        pprot;
    logic [7:0]        dprot;
    logic [7:0]        opt;
    logic [15:0]       blkCfg;
    logic [3:0][15:0]  keys;
    logic              bdBlocked;
    logic              dbgEn;
    logic              engGo;
    logic [2:0]        ccobIx;
    logic [5:0][15:0]  ccob;
    logic [3:0]        bdCnt;
  } fsric_regs_t;
endpackage : fsric_pkg
`default_nettype wire

// [fsric_ctrl.sv]
// Summary of operation
// - Command interrupt is complete flag AND its enable.
// - Error interrupt comes from double and single fault flags with enables.
// - Wait mode changes nothing; enabled complete interrupt wakes the system.
// - Stop request waits until the running command has finished.
// - Reset sequence loads security register from byte at 0x7F_FF0F.
// - Programmed security byte only takes effect after next reset.
// - With backdoor enabled, verify compares four 16-bit keys to stored keys.
// - Successful key match forces security state field to 10.
// - Keys of all zeros or all ones never match.
// - Program flash block 0 reads invalid while backdoor verify runs.
// - One failed comparison blocks further backdoor verifies until reset.
// - Backdoor verify leaves stored security, keys and protection untouched.
// - Special single chip erase-verify-all success unsecures and enables debug.
// - Every reset loads block config, both protections, option and security.
// - Reset sequence errors fall back to fully protected, secured defaults.
// - Double fault during reset sequence sets both verify error bits.
// - Complete flag clear during reset sequence; bus stalled in first part.
// - After stall, reads served but command object writes ignored.
// - Sequence end sets complete flag; command object writes then accepted.
// - Reset aborts any running command immediately.
// - Flags and enables live in status, config and error registers.
//
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
`include "fsric_consts.svh"
module fsric_ctrl #(
  parameter logic [7:0] CMD_BDKEY = 8'h0c,
  parameter logic [7:0] CMD_EVALL = 8'h01,
  parameter logic [3:0] BD_CYCLES = 4'h8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Configuration field read port
  output logic             nvmRdReq,
  output logic [22:0]      nvmAddr,
  input  wire logic        nvmRdValid,
  input  wire logic [15:0] nvmRdata,
  input  wire logic        nvmEccDbl,
  // Runtime ECC events from the read path
  input  wire logic        eccDbl,
  input  wire logic        eccSgl,
  // Command algorithm engine
  output logic             engStart,
  output logic [7:0]       engCmd,
  input  wire logic        engDone,
  input  wire logic        engErased,
  input  wire logic [1:0]  engMgstat,
  // System
  input  wire logic        sscMode,
  input  wire logic        stopReq,
  output logic             stopAck,
  output logic             pflashRdOk,
  output logic             debugEnable,
  output logic             secured,
  output logic             cmdIrq,
  output logic             errIrq
);
  fsric_pkg::fsric_regs_t st;
  fsric_pkg::fsric_regs_t next_st;

  function automatic logic [22:0] cfgAddr(input logic [2:0] step);
    logic [22:0] off;
    off = 23'h000000;
    if (step < `FSRIC_STEP_PROT) begin
      off = {19'h00000, step, 1'b0};
    end else if (step == `FSRIC_STEP_PROT) begin
      off = `FSRIC_CFG_PROTW;
    end else begin
      off = `FSRIC_CFG_OPTW;
    end
    return `FSRIC_CFG_BASE + off;
  endfunction : cfgAddr

  logic apbAcc;
  logic apbWr;
  logic inSeq;
  logic backdoor_key_enable_field;
  logic keysValid;
  logic keysMatch;
  logic bdMatch;
  logic mapped;
  logic [31:0] rdMux;
  logic [31:0] pw;

  assign inSeq = (st.state == fsric_pkg::S_HOLD) || (st.state == fsric_pkg::S_LOAD);
  // Bus held off only in the first part of the sequence
  assign pready = (st.state != fsric_pkg::S_HOLD);
  assign apbAcc = psel && penable && pready;
  assign apbWr = apbAcc && pwrite;
  assign pw = pwdata;
  assign backdoor_key_enable_field = (st.opt[7:6] == `FSRIC_KEY_EN) || (st.sec[7:6] == `FSRIC_KEY_EN);

  // Compare against keys latched at reset; flash itself is never written
  always_comb begin
    keysValid = 1'b1;
    keysMatch = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (st.ccob[i + 1] == `FSRIC_KEY_ZERO || st.ccob[i + 1] == `FSRIC_KEY_ONES) begin
        keysValid = 1'b0;
      end
      if (st.ccob[i + 1] != st.keys[i]) begin
        keysMatch = 1'b0;
      end
    end
  end
  assign bdMatch = backdoor_key_enable_field && !st.bdBlocked && keysValid && keysMatch;

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h00000000;
    if (paddr == `FSRIC_OFF_CFG) begin
      rdMux[`FSRIC_BIT_CMD_COMPLETE_IRQ_EN] = st.cmd_complete_irq_en;
    end else if (paddr == `FSRIC_OFF_ERRCFG) begin
      rdMux[`FSRIC_BIT_DFD] = st.double_fault_irq_en;
      rdMux[`FSRIC_BIT_SFD] = st.single_fault_irq_en;
    end else if (paddr == `FSRIC_OFF_STAT) begin
      rdMux[`FSRIC_BIT_CMD_COMPLETE_FLAG] = st.cmd_complete_flag;
      rdMux[1:0] = st.verify_error_status;
    end else if (paddr == `FSRIC_OFF_ERRSTAT) begin
      rdMux[`FSRIC_BIT_DFD] = st.double_fault_flag;
      rdMux[`FSRIC_BIT_SFD] = st.single_fault_flag;
    end else if (paddr == `FSRIC_OFF_SEC) begin
      rdMux[7:0] = st.sec;
    end else if (paddr == `FSRIC_OFF_PPROT) begin
      rdMux[7:0] = st.pprot;
    end else if (paddr == `FSRIC_OFF_DPROT) begin
      rdMux[7:0] = st.dprot;
    end else if (paddr == `FSRIC_OFF_OPT) begin
      rdMux[7:0] = st.opt;
    end else if (paddr == `FSRIC_OFF_IDX) begin
      rdMux[2:0] = st.ccobIx;
    end else if (paddr == `FSRIC_OFF_HI) begin
      // Indices past the last word read as zero instead of an unknown
      if (st.ccobIx <= `FSRIC_CCOB_LAST) begin
        rdMux[7:0] = st.ccob[st.ccobIx][15:8];
      end
    end else if (paddr == `FSRIC_OFF_LO) begin
      if (st.ccobIx <= `FSRIC_CCOB_LAST) begin
        rdMux[7:0] = st.ccob[st.ccobIx][7:0];
      end
    end else if (paddr == `FSRIC_OFF_BLKCFG) begin
      rdMux[15:0] = st.blkCfg;
    end else begin
      mapped = 1'b0;
    end
  end
  // Read data is a mux of flops so the answer needs no wait state
  assign prdata = (apbAcc && !pwrite) ? rdMux : 32'h00000000;
  assign pslverr = apbAcc && !mapped;

  always_comb begin
    next_st = st;
    next_st.engGo = 1'b0;
    // Runtime fault flags: set wins over write-one-to-clear
    if (apbWr && paddr == `FSRIC_OFF_ERRSTAT) begin
      if (pw[`FSRIC_BIT_DFD]) next_st.double_fault_flag = 1'b0;
      if (pw[`FSRIC_BIT_SFD]) next_st.single_fault_flag = 1'b0;
    end
    if (eccDbl) next_st.double_fault_flag = 1'b1;
    if (eccSgl) next_st.single_fault_flag = 1'b1;
    if (apbWr && paddr == `FSRIC_OFF_CFG) begin
      next_st.cmd_complete_irq_en = pw[`FSRIC_BIT_CMD_COMPLETE_IRQ_EN];
    end
    if (apbWr && paddr == `FSRIC_OFF_ERRCFG) begin
      next_st.double_fault_irq_en = pw[`FSRIC_BIT_DFD];
      next_st.single_fault_irq_en = pw[`FSRIC_BIT_SFD];
    end
    // Command object is writable only while idle and complete
    if (apbWr && st.cmd_complete_flag && st.state == fsric_pkg::S_IDLE) begin
      if (paddr == `FSRIC_OFF_IDX) begin
        next_st.ccobIx = pw[2:0];
      end else if (paddr == `FSRIC_OFF_HI && st.ccobIx <= `FSRIC_CCOB_LAST) begin
        next_st.ccob[st.ccobIx][15:8] = pw[7:0];
      end else if (paddr == `FSRIC_OFF_LO && st.ccobIx <= `FSRIC_CCOB_LAST) begin
        next_st.ccob[st.ccobIx][7:0] = pw[7:0];
      end
    end
    case (st.state)
      fsric_pkg::S_HOLD, fsric_pkg::S_LOAD: begin
        next_st.cmd_complete_flag = 1'b0;
        if (nvmRdValid) begin
          if (nvmEccDbl) begin
            next_st.seqErr = 1'b1;
            next_st.verify_error_status = 2'b11;
          end
          if (st.step < `FSRIC_STEP_HOLD) begin
            next_st.keys[st.step[1:0]] = nvmRdata;
          end else if (st.step == `FSRIC_STEP_HOLD) begin
            next_st.blkCfg = nvmRdata;
          end else if (st.step == `FSRIC_STEP_PROT) begin
            next_st.dprot = nvmRdata[15:8];
            next_st.pprot = nvmRdata[7:0];
          end else begin
            next_st.opt = nvmRdata[15:8];
            next_st.sec = nvmRdata[7:0];
          end
          next_st.step = st.step + 3'h1;
          if (st.step + 3'h1 == `FSRIC_STEP_HOLD) begin
            next_st.state = fsric_pkg::S_LOAD;
          end
          if (st.step == `FSRIC_STEP_LAST) begin
            next_st.state = fsric_pkg::S_IDLE;
            next_st.cmd_complete_flag = 1'b1;
            if (st.seqErr || nvmEccDbl) begin
              next_st.pprot = `FSRIC_PPROT_DEF;
              next_st.dprot = `FSRIC_DPROT_DEF;
              next_st.opt = `FSRIC_OPT_DEF;
              next_st.sec = `FSRIC_SEC_DEF;
              next_st.keys = '0;
            end
          end
        end
      end
      fsric_pkg::S_IDLE: begin
        // Programming the security byte does not touch the live register
        if (apbWr && paddr == `FSRIC_OFF_STAT && pw[`FSRIC_BIT_CMD_COMPLETE_FLAG] && st.cmd_complete_flag) begin
          next_st.cmd_complete_flag = 1'b0;
          next_st.verify_error_status = 2'b00;
          if (st.ccob[0][15:8] == CMD_BDKEY) begin
            next_st.state = fsric_pkg::S_BDKEY;
            next_st.bdCnt = BD_CYCLES;
          end else begin
            next_st.state = fsric_pkg::S_ENG;
            next_st.engGo = 1'b1;
          end
        end
      end
      fsric_pkg::S_BDKEY: begin
        if (st.bdCnt == 4'h0) begin
          next_st.state = fsric_pkg::S_IDLE;
          next_st.cmd_complete_flag = 1'b1;
          if (bdMatch) begin
            next_st.sec[1:0] = `FSRIC_SEC_UNSEC;
          end else if (backdoor_key_enable_field) begin
            next_st.bdBlocked = 1'b1;
          end
        end else begin
          next_st.bdCnt = st.bdCnt - 4'h1;
        end
      end
      fsric_pkg::S_ENG: begin
        if (engDone) begin
          next_st.state = fsric_pkg::S_IDLE;
          next_st.cmd_complete_flag = 1'b1;
          next_st.verify_error_status = engMgstat;
          if (st.ccob[0][15:8] == CMD_EVALL && sscMode && engErased && engMgstat == 2'b00) begin
            next_st.sec[1:0] = `FSRIC_SEC_UNSEC;
            next_st.dbgEn = 1'b1;
          end
        end
      end
      default: begin
        next_st.state = fsric_pkg::S_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // A running command is dropped here with no completion
      st <= '0;
      st.state <= fsric_pkg::S_HOLD;
    end else begin
      st <= next_st;
    end
  end

  assign nvmRdReq = inSeq;
  assign nvmAddr = cfgAddr(st.step);
  assign engStart = st.engGo;
  assign engCmd = st.ccob[0][15:8];
  assign stopAck = stopReq && st.cmd_complete_flag && !inSeq;
  assign pflashRdOk = (st.state != fsric_pkg::S_BDKEY);
  assign debugEnable = st.dbgEn;
  assign secured = (st.sec[1:0] != `FSRIC_SEC_UNSEC);
  // Interrupt path has no clock gating, so wait mode wakeup works
  assign cmdIrq = st.cmd_complete_flag && st.cmd_complete_irq_en;
  assign errIrq = (st.double_fault_flag && st.double_fault_irq_en) || (st.single_fault_flag && st.single_fault_irq_en);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence bdEnd;
    st.state == fsric_pkg::S_BDKEY && st.bdCnt == 4'h0;
  endsequence
  sequence engEnd;
    st.state == fsric_pkg::S_ENG && engDone;
  endsequence

  cmd_irq_a: assert property (engEnd ##0 st.cmd_complete_irq_en |=> cmdIrq)
    else $error("Command interrupt missing after completion");
  err_irq_a: assert property (eccDbl && st.double_fault_irq_en |=> errIrq)
    else $error("Error interrupt missing after double fault");
  stop_hold_a: assert property (st.state == fsric_pkg::S_ENG |-> !stopAck)
    else $error("Stop granted while command running");
  sec_load_a: assert property (st.state == fsric_pkg::S_LOAD && st.step == `FSRIC_STEP_LAST
      && nvmRdValid && !nvmEccDbl && !st.seqErr |=> st.sec == $past(nvmRdata[7:0]))
    else $error("Security register not loaded from config field");
  bd_unsec_a: assert property (bdEnd ##0 bdMatch |=> !secured && st.cmd_complete_flag)
    else $error("Backdoor match did not unsecure");
  bd_block_a: assert property (bdEnd ##0 (backdoor_key_enable_field && !bdMatch) |=> st.bdBlocked
      ##1 st.bdBlocked[*3])
    else $error("Failed backdoor did not block");
  blk0_a: assert property (st.state == fsric_pkg::S_BDKEY |-> !pflashRdOk)
    else $error("Block 0 readable during backdoor verify");
  seq_cmd_complete_flag_a: assert property (inSeq |-> !st.cmd_complete_flag)
    else $error("Complete flag set during reset sequence");
  hold_stall_a: assert property (st.state == fsric_pkg::S_HOLD |-> !pready)
    else $error("Bus not stalled in hold phase");
  ccob_ignore_a: assert property (inSeq && apbWr && paddr == `FSRIC_OFF_IDX
      |=> $stable(st.ccobIx))
    else $error("Command index written during reset sequence");
  seq_done_a: assert property (st.state == fsric_pkg::S_LOAD && st.step == `FSRIC_STEP_LAST
      && nvmRdValid |=> st.cmd_complete_flag && st.state == fsric_pkg::S_IDLE)
    else $error("Sequence end did not set complete flag");
  dbl_mg_a: assert property (inSeq && nvmRdValid && nvmEccDbl |=> st.verify_error_status == 2'b11)
    else $error("Double fault in sequence did not set verify bits");
  fallback_a: assert property (st.state == fsric_pkg::S_LOAD && st.step == `FSRIC_STEP_LAST
      && nvmRdValid && st.seqErr |=> secured && st.pprot == `FSRIC_PPROT_DEF)
    else $error("Sequence error did not fall back to protected");

  // Launch and pass conditions used by the backdoor launch and erase verify all checks
  sequence bdLaunch;
    st.state == fsric_pkg::S_IDLE && apbWr && paddr == `FSRIC_OFF_STAT
      && pw[`FSRIC_BIT_CMD_COMPLETE_FLAG] && st.ccob[0][15:8] == CMD_BDKEY;
  endsequence
  sequence evallPass;
    st.ccob[0][15:8] == CMD_EVALL && sscMode && engErased && engMgstat == 2'b00;
  endsequence

  sgl_irq_a: assert property (eccSgl && st.single_fault_irq_en |=> errIrq)
    else $error("Error interrupt missing after single fault");
  stop_grant_a: assert property (stopReq && st.state == fsric_pkg::S_IDLE
      |-> stopAck)
    else $error("Stop held off while idle");
  bd_launch_a: assert property (bdLaunch |=> !pflashRdOk && !st.cmd_complete_flag)
    else $error("Backdoor launch did not block reads");
  bd_keep_a: assert property (st.state == fsric_pkg::S_BDKEY |=> $stable(st.keys)
      && $stable(st.pprot) && $stable(st.dprot) && $stable(st.opt) && $stable(st.sec[7:2]))
    else $error("Backdoor verify changed stored settings");
  key_bad_a: assert property (bdEnd ##0 !keysValid |=> st.sec == $past(st.sec))
    else $error("Invalid backdoor key changed security");
  evall_unsec_a: assert property (engEnd ##0 evallPass |=> !secured && debugEnable)
    else $error("Erase verify all did not unsecure");
  sec_prog_a: assert property (st.state == fsric_pkg::S_ENG && !engDone
      |=> $stable(st.sec))
    else $error("Security changed while a command runs");
  // Reset must win over everything, so this check ignores the default disable
  rst_abort_a: assert property (@(posedge core_clk) disable iff (1'b0) srst
      |=> st.state == fsric_pkg::S_HOLD && !st.cmd_complete_flag && !engStart && st.step == '0)
    else $error("Reset did not abort the running command");
  seq_start_a: assert property ($fell(srst)
      |-> nvmRdReq && nvmAddr == `FSRIC_CFG_BASE)
    else $error("Reset sequence did not start at the config field");
  hi_ignore_a: assert property (inSeq && apbWr && paddr == `FSRIC_OFF_HI
      |=> $stable(st.ccob))
    else $error("Command word written during reset sequence");
  ccob_take_a: assert property (st.state == fsric_pkg::S_IDLE && apbWr
      && paddr == `FSRIC_OFF_IDX |=> st.ccobIx == $past(pwdata[2:0]))
    else $error("Command index write lost after sequence end");
  launch_go_a: assert property (st.state == fsric_pkg::S_IDLE && apbWr
      && paddr == `FSRIC_OFF_STAT && pw[`FSRIC_BIT_CMD_COMPLETE_FLAG] && st.ccob[0][15:8] != CMD_BDKEY
      |=> engStart && st.state == fsric_pkg::S_ENG && !st.cmd_complete_flag)
    else $error("Command launch did not start the engine");
endmodule : fsric_ctrl
`default_nettype wire

// [fsric_nvm_model.sv]
`default_nettype none
module fsric_nvm_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Config read port
  input  wire logic        nvmRdReq,
  input  wire logic [22:0] nvmAddr,
  output logic             nvmRdValid,
  output logic [15:0]      nvmRdata,
  output logic             nvmEccDbl,
  // Algorithm engine
  input  wire logic        engStart,
  output logic             engDone,
  output logic             engErased,
  output logic [1:0]       engMgstat,
  // Scenario controls
  input  wire logic        zeroKey,
  input  wire logic        injDbl,
  input  wire logic        erased
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rdCnt;
  logic [2:0] engCnt;

  function automatic logic [15:0] word(input logic [3:0] a);
    case (a)
      4'h0: word = zeroKey ? 16'h0000 : 16'h1234;
      4'h2: word = 16'h5678;
      4'h4: word = 16'h9abc;
      4'h6: word = 16'hdef0;
      4'h8: word = 16'h00a5;
      4'hc: word = 16'h3cc3;
      4'he: word = 16'h8001;
      default: word = 16'h0bad;
    endcase
  endfunction : word

  // Slow answer on purpose; the data line toggles whenever it is not valid
  always_ff @(posedge core_clk) begin
    nvmRdValid <= 1'b0;
    nvmEccDbl  <= 1'b0;
    nvmRdata   <= ~nvmRdata;
    engDone    <= 1'b0;
    if (srst || !nvmRdReq || nvmRdValid) begin
      rdCnt <= 3'h0;
    end else if (rdCnt == 3'h3) begin
      nvmRdValid <= 1'b1;
      nvmRdata   <= word(nvmAddr[3:0]);
      nvmEccDbl  <= injDbl && (nvmAddr[3:0] == 4'h8);
    end else begin
      rdCnt <= rdCnt + 3'h1;
    end
    if (srst) begin
      engCnt <= 3'h0;
    end else if (engStart) begin
      engCnt <= 3'h5;
    end else if (engCnt != 3'h0) begin
      engCnt  <= engCnt - 3'h1;
      engDone <= (engCnt == 3'h1);
    end
  end

  // Results are only meaningful with the done pulse
  assign engErased = engDone ? erased : ~erased;
  assign engMgstat = engDone ? 2'b00 : 2'b11;
endmodule : fsric_nvm_model
`default_nettype wire

// [flash_security_reset_irq_ctrl_tb.sv]
`default_nettype none
`include "fsric_consts.svh"
module flash_security_reset_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic nvmRdReq, nvmRdValid, nvmEccDbl, eccDbl, eccSgl, engStart, engDone;
  logic [22:0] nvmAddr;
  logic [15:0] nvmRdata;
  logic [7:0] engCmd;
  logic engErased, sscMode, stopReq, stopAck, pflashRdOk, debugEnable;
  logic secured, cmdIrq, errIrq, zeroKey, injDbl, erased;
  logic [1:0] engMgstat;
  logic [15:0] keys [4];
  int bad_count = 0;
  int comparisons = 0;
  int waits;

  fsric_ctrl u_dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .nvmRdReq(nvmRdReq), .nvmAddr(nvmAddr), .nvmRdValid(nvmRdValid),
    .nvmRdata(nvmRdata), .nvmEccDbl(nvmEccDbl), .eccDbl(eccDbl), .eccSgl(eccSgl),
    .engStart(engStart), .engCmd(engCmd), .engDone(engDone), .engErased(engErased),
    .engMgstat(engMgstat), .sscMode(sscMode), .stopReq(stopReq), .stopAck(stopAck),
    .pflashRdOk(pflashRdOk), .debugEnable(debugEnable), .secured(secured),
    .cmdIrq(cmdIrq), .errIrq(errIrq));

  fsric_nvm_model u_model (.core_clk(core_clk), .srst(srst), .nvmRdReq(nvmRdReq),
    .nvmAddr(nvmAddr), .nvmRdValid(nvmRdValid), .nvmRdata(nvmRdata),
    .nvmEccDbl(nvmEccDbl), .engStart(engStart), .engDone(engDone),
    .engErased(engErased), .engMgstat(engMgstat), .zeroKey(zeroKey),
    .injDbl(injDbl), .erased(erased));

  always #50 core_clk = ~core_clk;

  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; an idle cycle always precedes the setup phase
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge core_clk);
      waits++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic regs(input logic [7:0] s, p, d, o);
    rd(`FSRIC_OFF_SEC, {24'h0, s});
    rd(`FSRIC_OFF_PPROT, {24'h0, p});
    rd(`FSRIC_OFF_DPROT, {24'h0, d});
    rd(`FSRIC_OFF_OPT, {24'h0, o});
  endtask : regs

  task automatic do_reset();
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
  endtask : do_reset

  // Poll the status register; polling is bounded
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `FSRIC_OFF_STAT, 32'h0);
      n++;
    end while (rdat[7] !== 1'b1 && n < 100);
    chk({31'h0, rdat[7]}, 32'h1);
  endtask : wait_done

  task automatic launch(input logic [7:0] op);
    wr(`FSRIC_OFF_IDX, 32'h0);
    wr(`FSRIC_OFF_HI, {24'h0, op});
    for (int i = 0; i < 4; i++) begin
      wr(`FSRIC_OFF_IDX, 32'(i + 1));
      wr(`FSRIC_OFF_HI, {24'h0, keys[i][15:8]});
      wr(`FSRIC_OFF_LO, {24'h0, keys[i][7:0]});
    end
    wr(`FSRIC_OFF_STAT, 32'h80);
    @(negedge core_clk);
  endtask : launch

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {eccDbl, eccSgl, sscMode, stopReq, zeroKey, injDbl, erased} = '0;
    keys = '{default: 16'h0};
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(`FSRIC_OFF_STAT, 32'h0);
    chk({31'h0, waits > 8}, 32'h1);
    wr(`FSRIC_OFF_IDX, 32'h3);
    wr(`FSRIC_OFF_HI, 32'h5a);
    rd(`FSRIC_OFF_IDX, 32'h0);
    wait_done();
    rd(`FSRIC_OFF_HI, 32'h0);
    regs(8'h01, 8'hc3, 8'h3c, 8'h80);
    rd(`FSRIC_OFF_BLKCFG, 32'h00a5);
    wr(`FSRIC_OFF_IDX, 32'h3);
    rd(`FSRIC_OFF_IDX, 32'h3);
    rd(8'h3c, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(`FSRIC_OFF_CFG, 32'h80);
    @(negedge core_clk);
    chk({31'h0, cmdIrq}, 32'h1);
    for (int j = 0; j < 8; j++) begin
      wr(`FSRIC_OFF_ERRCFG, {30'h0, j[1:0]});
      @(posedge core_clk);
      eccDbl <= j[2];
      eccSgl <= !j[2];
      @(posedge core_clk);
      eccDbl <= 1'b0;
      eccSgl <= 1'b0;
      @(negedge core_clk);
      chk({31'h0, errIrq}, {31'h0, j[2] ? j[1] : j[0]});
      rd(`FSRIC_OFF_ERRSTAT, {30'h0, j[2], !j[2]});
      wr(`FSRIC_OFF_ERRSTAT, 32'h3);
    end
    stopReq <= 1'b1;
    launch(8'h40);
    chk({30'h0, cmdIrq, stopAck}, 32'h0);
    chk({24'h0, engCmd}, 32'h40);
    wait_done();
    @(negedge core_clk);
    chk({30'h0, cmdIrq, stopAck}, 32'h3);
    keys = '{16'h1111, 16'h5678, 16'h9abc, 16'hdef0};
    launch(8'h0c);
    chk({31'h0, pflashRdOk}, 32'h0);
    wait_done();
    keys[0] = 16'h1234;
    launch(8'h0c);
    wait_done();
    chk({31'h0, secured}, 32'h1);
    zeroKey <= 1'b1;
    do_reset();
    wait_done();
    keys[0] = 16'h0000;
    launch(8'h0c);
    wait_done();
    chk({31'h0, secured}, 32'h1);
    zeroKey <= 1'b0;
    do_reset();
    wait_done();
    keys[0] = 16'h1234;
    launch(8'h0c);
    wait_done();
    chk({31'h0, secured, pflashRdOk}, 32'h1);
    regs(8'h02, 8'hc3, 8'h3c, 8'h80);
    launch(8'h40);
    do_reset();
    wait_done();
    rd(`FSRIC_OFF_STAT, 32'h80);
    regs(8'h01, 8'hc3, 8'h3c, 8'h80);
    injDbl <= 1'b1;
    do_reset();
    wait_done();
    injDbl <= 1'b0;
    rd(`FSRIC_OFF_STAT, 32'h83);
    regs(8'hff, 8'h00, 8'h00, 8'hff);
    do_reset();
    wait_done();
    sscMode <= 1'b1;
    erased  <= 1'b1;
    launch(8'h01);
    wait_done();
    chk({30'h0, debugEnable, secured}, 32'h2);
    end_sim();
  end

  // Whole sequence needs about eight hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end
endmodule : flash_security_reset_irq_ctrl_tb
`default_nettype wire
